// File: smce_host_bfm.sv
/*
 * Host master model for the single-wire line: reset pulse, bit slots, bytes.
 * Assumes a pulled-up line whose level comes back on line; pull high = drive low.
 */
`timescale 1ns/1ps
module smce_host_bfm #(
  parameter int unsigned RST_CYC = 4000
) (
  input wire logic clk,
  input wire logic line,
  output logic pull,
  output logic vpp
);
  initial begin
    pull = 1'b0;
    vpp = 1'b0; // no programming voltage without a program command
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic line_reset(output logic pres);
    int n;
    pres = 1'b0;
    @(posedge clk);
    pull <= 1'b1;
    repeat (RST_CYC + 20) @(posedge clk);
    pull <= 1'b0;
    for (n = 0; n < 6000; n++) begin
      @(negedge clk);
      if (!line) pres = 1'b1;
      else if (pres) break;
    end
    repeat (20) @(posedge clk);
  endtask
  // write 1 and read share one slot shape: short start, sample mid-slot
  task automatic slot(input logic b, output logic r);
    @(posedge clk);
    pull <= 1'b1;
    repeat (b ? 8 : 3760) @(posedge clk);
    pull <= 1'b0;
    if (b) begin
      repeat (1800) @(posedge clk);
      @(negedge clk);
      r = line;
      repeat (1960) @(posedge clk);
    end else begin
      r = 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 0; i < 8; i++) slot(d[i], q[i]);
  endtask
endmodule

// File: smce_line.sv
/*
 * Single-wire line front end: slot timing, reset detection, presence pulse.
 * Assumes the line input is already synchronous to clk; oe high pulls low.
 */
`timescale 1ns/1ps
module smce_line #(
  parameter int unsigned RESET_LOW_CYC = smce_pkg::RESET_LOW_CYC,
  parameter int unsigned PRES_LEN_CYC = smce_pkg::PRES_LEN_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic line_in,
  input wire logic tx_en,
  input wire logic tx_bit,
  output logic line_oe,
  output smce_pkg::smce_slot_t ev
);

  localparam int unsigned W = smce_pkg::TIMER_W;

  typedef enum logic [2:0] {L_IDLE, L_SLOT, L_RST, L_PWAIT, L_PRES} smce_lst_t;

  smce_lst_t st_q;
  logic line_d1_q;
  logic [W-1:0] low_q;
  logic [W-1:0] cnt_q;

  wire fall = line_d1_q & ~line_in;
  wire long_low = ~line_in && low_q == W'(RESET_LOW_CYC - 1);
  wire sample_hit = cnt_q == W'(smce_pkg::SLOT_SAMPLE_CYC - 1);
  wire pwait_hit = cnt_q == W'(smce_pkg::PRES_WAIT_CYC - 1);
  wire pres_hit = cnt_q == W'(PRES_LEN_CYC - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_d1_q <= 1'b1;
      low_q <= '0;
    end else begin
      line_d1_q <= line_in;
      low_q <= line_in ? '0 : (long_low ? low_q : low_q + W'(1));
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= L_IDLE;
      cnt_q <= '0;
      line_oe <= 1'b0;
      ev <= '0;
    end else begin
      ev <= '0;
      cnt_q <= cnt_q + W'(1);
      if (long_low) begin
        st_q <= L_RST;
        line_oe <= 1'b0;
        ev.line_reset <= 1'b1;
      end else begin
        unique case (st_q)
          L_IDLE: begin
            if (fall) begin
              st_q <= L_SLOT;
              cnt_q <= '0;
              ev.fall <= 1'b1;
            end
          end
          L_SLOT: begin
            if (cnt_q == '0) begin
              line_oe <= tx_en & ~tx_bit;
            end
            if (sample_hit) begin
              st_q <= L_IDLE;
              line_oe <= 1'b0;
              ev.done <= 1'b1;
              ev.bit_val <= line_in;
            end
          end
          L_RST: begin
            if (line_in) begin
              st_q <= L_PWAIT;
              cnt_q <= '0;
            end
          end
          L_PWAIT: begin
            if (pwait_hit) begin
              st_q <= L_PRES;
              cnt_q <= '0;
              line_oe <= 1'b1;
            end
          end
          L_PRES: begin
            if (pres_hit) begin
              st_q <= L_IDLE;
              line_oe <= 1'b0;
            end
          end
          default: begin
            st_q <= L_IDLE;
            line_oe <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// File: smce_pkg.sv
/*
 * Shared constants, the slot-event carrier and the CRC step for the status
 * memory command engine of a single-wire OTP memory slave.
 * Assumes one 125 MHz clock; all slot timing is counted in that clock.
 */
package smce_pkg;

  localparam int unsigned CLK_MHZ = 125;

  // slot and reset timing, in microseconds and derived cycles
  localparam int unsigned RESET_LOW_US = 480;
  localparam int unsigned RESET_LOW_CYC = RESET_LOW_US * CLK_MHZ;
  localparam int unsigned SLOT_SAMPLE_US = 30;
  localparam int unsigned SLOT_SAMPLE_CYC = SLOT_SAMPLE_US * CLK_MHZ;
  localparam int unsigned PRES_WAIT_US = 30;
  localparam int unsigned PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
  localparam int unsigned PRES_LEN_US = 120;
  localparam int unsigned PRES_LEN_CYC = PRES_LEN_US * CLK_MHZ;
  localparam int unsigned TIMER_W = 17;

  // ROM-level command codes
  localparam logic [7:0] CMD_READ_ROM = 8'h33;
  localparam logic [7:0] CMD_MATCH_ROM = 8'h55;
  localparam logic [7:0] CMD_SEARCH_ROM = 8'hf0;
  localparam logic [7:0] CMD_SKIP_ROM = 8'hcc;

  // function-level command codes
  localparam logic [7:0] CMD_READ_FIELD = 8'hf0;
  localparam logic [7:0] CMD_READ_STATUS = 8'haa;
  localparam logic [7:0] CMD_READ_PAGE = 8'hc3;
  localparam logic [7:0] CMD_WRITE_MEM = 8'h0f;
  localparam logic [7:0] CMD_PROFILE = 8'h99;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'h5a;

  localparam logic [7:0] PROFILE_REPLY = 8'h55;
  localparam logic [7:0] STATUS_ERASED = 8'hff;
  localparam logic [7:0] STATUS_FACTORY = 8'h00;
  localparam logic [2:0] STATUS_LAST = 3'h7;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [5:0] ROM_BIT_LAST = 6'h3f;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // reflected form of x8 + x5 + x4 + 1
  localparam logic [7:0] CRC_POLY_REFL = 8'h8c;

  typedef struct packed {
    logic fall;
    logic done;
    logic bit_val;
    logic line_reset;
  } smce_slot_t;

  // one bit into the CRC, LSB-first bit order
  function automatic logic [7:0] smce_crc_step(input logic [7:0] crc, input logic b);
    logic fb;
    fb = crc[0] ^ b;
    smce_crc_step = (crc >> 1) ^ (fb ? CRC_POLY_REFL : 8'h00);
  endfunction

endpackage

// File: smce_stat_mem.sv
/*
 * Eight-byte status field: seven programmable OTP bytes and one fixed byte.
 * Assumes writes come only from the command engine after a program pulse.
 */
`timescale 1ns/1ps
module smce_stat_mem (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] rd_idx,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_q
);

  logic [7:0] mem_q [0:6];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 7; i++) begin
        mem_q[i] <= smce_pkg::STATUS_ERASED;
      end
    end else if (wr_en && rd_idx != smce_pkg::STATUS_LAST) begin
      mem_q[rd_idx] <= mem_q[rd_idx] & wr_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= smce_pkg::STATUS_ERASED;
    end else if (rd_idx == smce_pkg::STATUS_LAST) begin
      rd_q <= smce_pkg::STATUS_FACTORY;
    end else begin
      rd_q <= mem_q[rd_idx];
    end
  end

endmodule

// File: smce_tb_top.sv
/*
 * Self-checking bench: profile query, abort by line reset, status read.
 * Assumes smce_top with shortened reset and presence counts.
 */
`timescale 1ns/1ps
module smce_tb_top;
  localparam int unsigned RST_CYC = 4000;
  localparam int unsigned PRES_CYC = 100;
  logic CLK;
  logic NRST;
  logic host_pull;
  logic vpp;
  logic dq_out;
  logic dq_oe;
  wire logic dq_line;
  int err_total;
  int n_tests;
  integer seed;
  // pulled-up open-drain line
  assign dq_line = (dq_oe ? dq_out : 1'b1) & !host_pull;
  smce_top #(
    .RESET_LOW_CYC(RST_CYC),
    .PRES_LEN_CYC(PRES_CYC)
  ) dut_u (
    .CLK(CLK),
    .NRST(NRST),
    .DQ_IN(dq_line),
    .DQ_OUT(dq_out),
    .DQ_OE(dq_oe),
    .VPP_DET(vpp)
  );
  smce_host_bfm #(
    .RST_CYC(RST_CYC)
  ) host_u (
    .clk(CLK),
    .line(dq_line),
    .pull(host_pull),
    .vpp(vpp)
  );
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc_b(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++) r = (r[0] ^ d[i]) ? ((r >> 1) ^ 8'h8c) : (r >> 1);
    return r;
  endfunction
  function automatic logic [7:0] exp_stat(input logic [2:0] idx);
    return (idx == 3'h7) ? 8'h00 : 8'hff;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  initial begin
    logic p;
    logic [7:0] q;
    logic [7:0] alo;
    logic [7:0] ahi;
    logic [7:0] crc;
    err_total = 0;
    n_tests = 0;
    seed = 32'h0b35;
    NRST = 1'b0;
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    repeat (2) @(posedge CLK);
    host_u.line_reset(p);
    check({7'h00, p}, 8'h01, "presence");
    host_u.xfer(smce_pkg::CMD_SKIP_ROM, q);
    host_u.xfer(smce_pkg::CMD_PROFILE, q);
    host_u.xfer(8'hff, q);
    check(q, 8'h55, "profile reply");
    // abort the finished query; a stale state would spoil the header below
    host_u.line_reset(p);
    check({7'h00, p}, 8'h01, "presence after abort");
    alo = 8'($random(seed));
    ahi = 8'($random(seed));
    alo[2:0] = 3'h6;
    host_u.xfer(smce_pkg::CMD_SKIP_ROM, q);
    host_u.xfer(smce_pkg::CMD_READ_STATUS, q);
    host_u.xfer(alo, q);
    host_u.xfer(ahi, q);
    host_u.xfer(8'hff, q);
    crc = crc_b(crc_b(crc_b(8'h00, 8'haa), alo), ahi);
    check(q, crc, "read header crc");
    crc = 8'h00;
    for (int i = 6; i < 8; i++) begin
      host_u.xfer(8'hff, q);
      check(q, exp_stat(3'(i)), "status byte");
      crc = crc_b(crc, exp_stat(3'(i)));
    end
    host_u.xfer(8'hff, q);
    check(q, crc, "status crc");
    host_u.xfer(8'hff, q);
    check(q, 8'hff, "after crc");
    wrap_up();
  end
endmodule

// File: smce_top.sv
/*
 * Command engine of a single-wire OTP memory slave: ROM selection, status
 * read and write, program profile. Data-memory commands are decoded but
 * answered with a released line. Assumes DQ_IN synchronous to CLK and
 * VPP_DET high while the line sits at programming voltage.
 */
`timescale 1ns/1ps
module smce_top #(
  parameter int unsigned RESET_LOW_CYC = smce_pkg::RESET_LOW_CYC,
  parameter int unsigned PRES_LEN_CYC = smce_pkg::PRES_LEN_CYC,
  // arbitrary identity value
  parameter logic [63:0] ROM_ID = 64'h5a00_0000_1234_56a1
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic DQ_IN,
  output logic DQ_OUT,
  output logic DQ_OE,
  input wire logic VPP_DET
);

  typedef enum logic [4:0] {
    S_ROMCMD, S_ROMRD, S_MATCH, S_SEARCH, S_FNCMD, S_ALO, S_AHI, S_HDRCRC,
    S_RSDATA, S_RSCRC, S_WSDATA, S_WSCRC, S_WSPCMD, S_WSPULSE, S_WSVER,
    S_PROFILE, S_ONES
  } smce_st_t;

  smce_pkg::smce_slot_t ev;
  smce_st_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sr_q, sr_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] crc_q, crc_d;
  logic [7:0] cmd_q, cmd_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  logic [2:0] rb_q, rb_d;
  logic [5:0] bidx_q, bidx_d;
  logic [1:0] ph_q, ph_d;
  logic miss_q, miss_d;
  logic pend_q, pend_d;
  logic vpp_d1_q;
  logic prog_wr;
  logic [7:0] mem_rd;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire [7:0] rx_byte = {ev.bit_val, sr_q[7:1]};
  wire byte_end = ev.done && cnt_q == smce_pkg::BYTE_LAST;
  wire [7:0] rom_byte = ROM_ID[{rb_q, 3'b000} +: 8];
  wire rom_bit = ROM_ID[bidx_q];
  wire [15:0] addr_inc = addr_q + 16'h0001;
  wire vpp_fall = vpp_d1_q & ~VPP_DET;
  wire rom_phase = st_q == S_ROMCMD || st_q == S_ROMRD || st_q == S_MATCH ||
                   st_q == S_SEARCH;
  wire rx_crc = st_q == S_FNCMD || st_q == S_ALO || st_q == S_AHI ||
                st_q == S_WSDATA;
  wire tx_mode = st_q == S_ROMRD || st_q == S_HDRCRC || st_q == S_RSDATA ||
                 st_q == S_RSCRC || st_q == S_WSCRC || st_q == S_WSVER ||
                 st_q == S_PROFILE || (st_q == S_SEARCH && ph_q != 2'd2);
  // the slot's first edge sees the fall before tx_q is reloaded, so take the fresh source bit
  wire tx_now = (ev.fall && pend_q) ? tx_src[0] : tx_q[0];
  wire tx_bit = (st_q == S_SEARCH) ? (rom_bit ^ ph_q[0]) : tx_now;

  logic [7:0] tx_src;
  always_comb begin
    unique case (st_q)
      S_ROMRD: tx_src = rom_byte;
      S_RSDATA, S_WSVER: tx_src = mem_rd;
      S_PROFILE: tx_src = smce_pkg::PROFILE_REPLY;
      default: tx_src = crc_q;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sr_d = sr_q;
    tx_d = tx_q;
    crc_d = crc_q;
    cmd_d = cmd_q;
    addr_d = addr_q;
    data_d = data_q;
    rb_d = rb_q;
    bidx_d = bidx_q;
    ph_d = ph_q;
    miss_d = miss_q;
    pend_d = pend_q;
    prog_wr = 1'b0;
    if (ev.fall && pend_q) begin
      tx_d = tx_src;
      pend_d = 1'b0;
    end
    if (rom_phase) begin
      crc_d = smce_pkg::CRC_INIT;
    end
    if (ev.done) begin
      cnt_d = cnt_q + 3'd1;
      sr_d = rx_byte;
      tx_d = tx_q >> 1;
      if (rx_crc) begin
        crc_d = smce_pkg::smce_crc_step(crc_q, ev.bit_val);
      end else if (st_q == S_RSDATA) begin
        crc_d = smce_pkg::smce_crc_step(crc_q, tx_q[0]);
      end
    end
    unique case (st_q)
      S_ROMCMD: begin
        if (byte_end) begin
          rb_d = '0;
          miss_d = 1'b0;
          bidx_d = '0;
          ph_d = '0;
          unique case (rx_byte)
            smce_pkg::CMD_READ_ROM: begin
              st_d = S_ROMRD;
              pend_d = 1'b1;
            end
            smce_pkg::CMD_MATCH_ROM: st_d = S_MATCH;
            smce_pkg::CMD_SEARCH_ROM: st_d = S_SEARCH;
            smce_pkg::CMD_SKIP_ROM: st_d = S_FNCMD;
            default: st_d = S_ONES;
          endcase
        end
      end
      S_ROMRD: begin
        if (byte_end) begin
          rb_d = rb_q + 3'd1;
          pend_d = rb_q != smce_pkg::BYTE_LAST;
          if (rb_q == smce_pkg::BYTE_LAST) begin
            st_d = S_FNCMD;
          end
        end
      end
      S_MATCH: begin
        if (byte_end) begin
          rb_d = rb_q + 3'd1;
          miss_d = miss_q | (rx_byte != rom_byte);
          if (rb_q == smce_pkg::BYTE_LAST) begin
            st_d = (miss_q | (rx_byte != rom_byte)) ? S_ONES : S_FNCMD;
          end
        end
      end
      S_SEARCH: begin
        if (ev.done) begin
          ph_d = ph_q + 2'd1;
          if (ph_q == 2'd2) begin
            ph_d = '0;
            bidx_d = bidx_q + 6'd1;
            if (ev.bit_val != rom_bit) begin
              st_d = S_ONES;
            end else if (bidx_q == smce_pkg::ROM_BIT_LAST) begin
              st_d = S_FNCMD;
            end
          end
        end
      end
      S_FNCMD: begin
        if (byte_end) begin
          cmd_d = rx_byte;
          unique case (rx_byte)
            smce_pkg::CMD_READ_STATUS, smce_pkg::CMD_WRITE_STATUS: st_d = S_ALO;
            smce_pkg::CMD_PROFILE: begin
              st_d = S_PROFILE;
              pend_d = 1'b1;
            end
            smce_pkg::CMD_READ_FIELD, smce_pkg::CMD_READ_PAGE,
            smce_pkg::CMD_WRITE_MEM: st_d = S_ONES;
            default: st_d = S_ONES;
          endcase
        end
      end
      S_ALO: begin
        if (byte_end) begin
          addr_d[7:0] = rx_byte;
          st_d = S_AHI;
        end
      end
      S_AHI: begin
        if (byte_end) begin
          addr_d[15:8] = rx_byte;
          if (cmd_q == smce_pkg::CMD_READ_STATUS) begin
            st_d = S_HDRCRC;
            pend_d = 1'b1;
          end else begin
            st_d = S_WSDATA;
          end
        end
      end
      S_HDRCRC: begin
        if (byte_end) begin
          st_d = S_RSDATA;
          crc_d = smce_pkg::CRC_INIT;
          pend_d = 1'b1;
        end
      end
      S_RSDATA: begin
        if (byte_end) begin
          pend_d = 1'b1;
          if (addr_q[2:0] == smce_pkg::STATUS_LAST) begin
            st_d = S_RSCRC;
          end else begin
            addr_d = addr_inc;
          end
        end
      end
      S_RSCRC: begin
        if (byte_end) begin
          st_d = S_ONES;
        end
      end
      S_WSDATA: begin
        if (byte_end) begin
          data_d = rx_byte;
          st_d = S_WSCRC;
          pend_d = 1'b1;
        end
      end
      S_WSCRC: begin
        if (byte_end) begin
          st_d = S_WSPCMD;
        end
      end
      S_WSPCMD: begin
        if (byte_end) begin
          st_d = (rx_byte == smce_pkg::CMD_PROGRAM) ? S_WSPULSE : S_ONES;
        end
      end
      S_WSPULSE: begin
        if (vpp_fall) begin
          prog_wr = 1'b1;
          st_d = S_WSVER;
          pend_d = 1'b1;
        end
      end
      S_WSVER: begin
        if (byte_end) begin
          addr_d = addr_inc;
          crc_d = addr_inc[7:0];
          st_d = S_WSDATA;
        end
      end
      S_PROFILE: begin
        if (byte_end) begin
          st_d = S_ONES;
        end
      end
      S_ONES: begin
        st_d = S_ONES;
      end
      default: st_d = S_ONES;
    endcase
    if (ev.line_reset) begin
      st_d = S_ROMCMD;
      cnt_d = '0;
      pend_d = 1'b0;
      crc_d = smce_pkg::CRC_INIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_q <= S_ROMCMD;
      cnt_q <= '0;
      sr_q <= '0;
      tx_q <= '0;
      crc_q <= smce_pkg::CRC_INIT;
      cmd_q <= '0;
      addr_q <= '0;
      data_q <= smce_pkg::STATUS_ERASED;
      rb_q <= '0;
      bidx_q <= '0;
      ph_q <= '0;
      miss_q <= 1'b0;
      pend_q <= 1'b0;
      vpp_d1_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      tx_q <= tx_d;
      crc_q <= crc_d;
      cmd_q <= cmd_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rb_q <= rb_d;
      bidx_q <= bidx_d;
      ph_q <= ph_d;
      miss_q <= miss_d;
      pend_q <= pend_d;
      vpp_d1_q <= VPP_DET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instances

  smce_line #(
    .RESET_LOW_CYC(RESET_LOW_CYC),
    .PRES_LEN_CYC(PRES_LEN_CYC)
  ) u_line (
    .clk(CLK),
    .nrst(NRST),
    .line_in(DQ_IN),
    .tx_en(tx_mode),
    .tx_bit(tx_bit),
    .line_oe(DQ_OE),
    .ev(ev)
  );

  smce_stat_mem u_mem (
    .clk(CLK),
    .nrst(NRST),
    .rd_idx(addr_q[2:0]),
    .wr_en(prog_wr),
    .wr_data(data_q),
    .rd_q(mem_rd)
  );

  // open-drain: only ever pulls low
  assign DQ_OUT = 1'b0;

endmodule

// File: smce_top_chk.sv
/*
 * Pin checker for the command engine: slot answers, presence, quiet times.
 * Assumes only the pins of smce_top; bound to every instance of it.
 */
`timescale 1ns/1ps
module smce_top_chk #(
  parameter int unsigned RESET_LOW_CYC = smce_pkg::RESET_LOW_CYC,
  parameter int unsigned PRES_LEN_CYC = smce_pkg::PRES_LEN_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic DQ_IN,
  input wire logic DQ_OUT,
  input wire logic DQ_OE,
  input wire logic VPP_DET
);
  logic [15:0] lo_q;
  logic [15:0] hi_q;
  logic [15:0] oe_q;
  logic [15:0] lo_d;
  logic [15:0] hi_d;
  logic [15:0] oe_d;
  logic [15:0] pw_q;
  logic pw_act_q;
  wire pw_start = DQ_IN && lo_q >= 16'(RESET_LOW_CYC) && lo_q != 16'h0000;
  // saturating run lengths of line low, line high and pull-down
  assign lo_d = DQ_IN ? 16'h0000 : lo_q + 16'(lo_q != 16'hffff);
  assign hi_d = !DQ_IN ? 16'h0000 : hi_q + 16'(hi_q != 16'hffff);
  assign oe_d = !DQ_OE ? 16'h0000 : oe_q + 16'(oe_q != 16'hffff);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lo_q <= 16'h0000;
      hi_q <= 16'h0000;
      oe_q <= 16'h0000;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
      oe_q <= oe_d;
    end
  end
  // cycles since the line came back high after a long low, until presence starts
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pw_q <= 16'h0000;
      pw_act_q <= 1'b0;
    end else if (pw_start) begin
      pw_q <= 16'h0000;
      pw_act_q <= 1'b1;
    end else if (pw_act_q) begin
      pw_q <= pw_q + 16'(pw_q != 16'hffff);
      pw_act_q <= !DQ_OE;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  sequence quiet_s;
    !DQ_OE [*8];
  endsequence
  sequence pres_s;
    $rose(DQ_OE) && pw_act_q;
  endsequence
  AST_OUT_LOW: assert property (DQ_OUT == 1'b0)
    else $error("data pin output value not low");
  AST_NRST_QUIET: assert property ($rose(NRST) |-> quiet_s)
    else $error("line pulled right after reset release");
  AST_PRESENCE: assert property ($rose(DQ_IN) && lo_q >= RESET_LOW_CYC |-> quiet_s)
    else $error("line pulled right after long low");
  AST_PRES_WAIT: assert property (pres_s |-> pw_q >= 16'd3680 && pw_q <= 16'd3790)
    else $error("presence pulse at wrong time");
  AST_PRES_DUE: assert property (pw_act_q |-> pw_q <= 16'd3790)
    else $error("no presence pulse after long low");
  AST_LONG_LOW: assert property (lo_q > 16'h0ed8 |-> !DQ_OE)
    else $error("line pulled during long low");
  AST_PULL_CAUSE: assert property ($rose(DQ_OE) |-> !$past(DQ_IN) || hi_q >= 16'h0e10)
    else $error("pull-down outside slot or presence");
  AST_PULL_HOLD: assert property ($rose(DQ_OE) |-> DQ_OE [*8])
    else $error("pull-down too short");
  AST_PULL_LEN: assert property ($fell(DQ_OE) |->
    (oe_q >= 16'(PRES_LEN_CYC - 1) && oe_q <= 16'(PRES_LEN_CYC + 1)) ||
    (oe_q >= 16'h0e9c && oe_q <= 16'h0eb0))
    else $error("pull-down length wrong");
  AST_RELEASE_QUIET: assert property ($fell(DQ_OE) |-> !DQ_OE [*2])
    else $error("pull-down restarted at once");
endmodule

bind smce_top smce_top_chk #(
  .RESET_LOW_CYC(RESET_LOW_CYC),
  .PRES_LEN_CYC(PRES_LEN_CYC)
) chk_u (
  .CLK(CLK),
  .NRST(NRST),
  .DQ_IN(DQ_IN),
  .DQ_OUT(DQ_OUT),
  .DQ_OE(DQ_OE),
  .VPP_DET(VPP_DET)
);
